// file: rtl/sspl_pin_logic.sv
// Pin logic of a two-channel serial controller with an AXI4-Lite register slave
//
// Overview of operation
// - Auto enable set: low clear-to-send enables that channel's transmitter.
// - Clear-to-send edges both ways are detected and can request an interrupt.
// - Auto enable set: carrier detect enables receiver; else general input with events.
// - Async with auto enable: request-to-send rises only after transmitter empties.
// - Auto enable off, except SDLC with feature bit: request-to-send pin is inverse of its control bit.
// - SDLC with feature bit: request-to-send released after closing flag left.
// - Async receive, no crystal: sync pin is input updating only status.
// - External sync: low sync input starts character assembly at prior clock edge.
// - Internal mono/bisync: sync pin outputs a pulse per recognised pattern.
// - SDLC: sync pin outputs flag receipt; becomes output once sync enabled.
// - Ready/request pin follows ready bit, or transmit DMA request when selected.
// - Request release: wait-pin timing with feature bit, else four clocks.
// - Wait/request pin resets to wait, open-drain; driven when request.
// - Receive clock may be 1, 16, 32 or 64 times bit rate.
// - During acknowledge, enable-out high only if enable-in high, nothing pending.
// - During acknowledge with enable-in high, vector driven once read strobe active.
// - Acknowledge input captured on rising edge of the master clock.
// - Open-drain active-low interrupt asserted while a request is pending and no interrupt is under service.
// - Address strobe and data strobe low together mean a reset request.
module sspl_pin_logic
	import sspl_pkg::*;
#(
	parameter int unsigned CH = NUM_CH
)
(
	input  wire logic              aclk,                 // Master clock
	input  wire logic              aresetn,              // Synchronous reset, active low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,         // Write address
	input  wire logic              s_axi_awvalid,        // Write address valid
	output logic                   s_axi_awready,        // Write address ready
	input  wire logic [31:0]       s_axi_wdata,          // Write data
	input  wire logic [3:0]        s_axi_wstrb,          // Write byte enables
	input  wire logic              s_axi_wvalid,         // Write data valid
	output logic                   s_axi_wready,         // Write data ready
	output logic [1:0]             s_axi_bresp,          // Write response
	output logic                   s_axi_bvalid,         // Write response valid
	input  wire logic              s_axi_bready,         // Write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,         // Read address
	input  wire logic              s_axi_arvalid,        // Read address valid
	output logic                   s_axi_arready,        // Read address ready
	output logic [31:0]            s_axi_rdata,          // Read data
	output logic [1:0]             s_axi_rresp,          // Read response
	output logic                   s_axi_rvalid,         // Read data valid
	input  wire logic              s_axi_rready,         // Read data ready
	input  wire logic [CH-1:0]     cts_n,                // Clear-to-send pins
	input  wire logic [CH-1:0]     dcd_n,                // Carrier-detect pins
	input  wire logic [CH-1:0]     sync_pin_i,           // Sync pin level
	output logic [CH-1:0]          sync_pin_o,           // Sync pin drive value
	output logic [CH-1:0]          sync_pin_oe,          // Sync pin drive enable
	input  wire logic [CH-1:0]     rx_tx_clock_pin,      // Receive clock pins
	output logic [CH-1:0]          rts_n,                // Request-to-send pins
	output logic [CH-1:0]          terminal_ready_or_request_n, // Ready/request pins
	output logic [CH-1:0]          wait_or_request_o,    // Wait/request drive value
	output logic [CH-1:0]          wait_or_request_oe,   // Wait/request drive enable
	input  wire logic              chain_enable_in,      // Daisy-chain enable in
	output logic                   chain_enable_out,     // Daisy-chain enable out
	output logic                   int_o,                // Interrupt drive value
	output logic                   int_oe,               // Interrupt drive enable
	input  wire logic              irq_acknowledge_n,    // Acknowledge strobe
	input  wire logic              read_strobe_n,        // Host read strobe
	output logic [7:0]             data_o,               // Vector drive value
	output logic                   data_oe,              // Vector drive enable
	input  wire logic              address_strobe_n,     // Muxed-bus address strobe
	input  wire logic              data_strobe_n,        // Muxed-bus data strobe
	output logic                   reset_request,        // Strobes both low
	input  wire logic [CH-1:0]     tx_empty,             // Transmitter drained
	input  wire logic [CH-1:0]     closing_flag_done,    // Closing flag left data pin
	input  wire logic [CH-1:0]     sync_found,           // Sync pattern recognised
	input  wire logic [CH-1:0]     flag_found,           // SDLC flag received
	input  wire logic [CH-1:0]     tx_dma_need,          // Transmitter wants data
	input  wire logic [CH-1:0]     wait_need,            // Host must wait / DMA due
	output logic [CH-1:0]          tx_enable,            // Transmitter allowed
	output logic [CH-1:0]          rx_enable,            // Receiver allowed
	output logic [CH-1:0]          rx_sample_tick,       // One pulse per bit time
	output logic [CH-1:0]          char_start            // Begin character assembly
);

	// =====================================================================
	// Shared synchroniser for bus-side strobes
	logic [3:0] bus_meta;
	logic [3:0] bus_sync;
	logic       ien_s;
	logic       ack_s;
	logic       rd_s;
	logic       rd_prev;
	logic [3:0] bus_raw;

	assign bus_raw = {chain_enable_in, irq_acknowledge_n, read_strobe_n,
		address_strobe_n | data_strobe_n};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_meta <= 4'hf;
			bus_sync <= 4'hf;
		end
		else
		begin
			bus_meta <= bus_raw;
			bus_sync <= bus_meta;
		end
	end

	assign ien_s = bus_sync[3];
	assign ack_s = ~bus_sync[2];
	assign rd_s  = ~bus_sync[1];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reset_request <= 1'b0;
		else
			reset_request <= ~bus_sync[0];
	end

	// =====================================================================
	// Register file and AXI4-Lite slave
	sspl_cfg_t         cfg [CH];
	logic [CH-1:0][7:0] status;
	logic [7:0]        vector;
	logic              ius;
	logic              pending;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_held;
	logic              w_held;
	logic              commit;
	logic [7:0]        wbyte;
	logic              wr_ch;
	logic [7:0]        wr_ofs;
	logic              rd_ch;
	logic [7:0]        rd_ofs;
	logic [7:0]        next_rdata;
	logic              rd_hit;

	assign commit = aw_held & w_held & ~s_axi_bvalid;
	assign wbyte  = w_data[7:0];
	assign wr_ch  = aw_addr[CH_SEL_BIT];
	assign wr_ofs = aw_addr & ~CH_STRIDE;
	assign rd_ch  = s_axi_araddr[CH_SEL_BIT];
	assign rd_ofs = s_axi_araddr & ~CH_STRIDE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (!aw_held && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (!w_held && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (commit)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= ((aw_addr < CH_SPAN) ? (wr_ofs inside {OFS_RX_CTRL, OFS_TX_CTRL,
					OFS_LINE_MODE, OFS_MISC, OFS_EXT, OFS_STATUS}) : (aw_addr == OFS_VECTOR
					|| aw_addr == OFS_IRQ_CTRL)) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		rd_hit     = 1'b1;
		next_rdata = '0;
		if (s_axi_araddr < CH_SPAN)
		begin
			unique case (rd_ofs)
				OFS_RX_CTRL:   next_rdata = cfg[rd_ch].rx_ctrl;
				OFS_TX_CTRL:   next_rdata = cfg[rd_ch].tx_ctrl;
				OFS_LINE_MODE: next_rdata = cfg[rd_ch].line_mode;
				OFS_MISC:      next_rdata = cfg[rd_ch].misc;
				OFS_EXT:       next_rdata = cfg[rd_ch].ext;
				OFS_STATUS:    next_rdata = status[rd_ch];
				default:       rd_hit = 1'b0;
			endcase
		end
		else if (s_axi_araddr == OFS_VECTOR)
			next_rdata = vector;
		else if (s_axi_araddr == OFS_IRQ_CTRL)
		begin
			next_rdata[IRQ_IUS]  = ius;
			next_rdata[IRQ_PEND] = pending;
		end
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, next_rdata};
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else
			s_axi_arready <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			vector <= VECTOR_RESET;
		else if (commit && w_strb[0] && aw_addr == OFS_VECTOR)
			vector <= wbyte;
	end

	// =====================================================================
	// Interrupt daisy chain and vector
	logic [CH-1:0] ch_pending;
	logic          ius_clr;

	assign pending = |ch_pending;
	assign ius_clr = commit && w_strb[0] && aw_addr == OFS_IRQ_CTRL && wbyte[IRQ_IUS];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_prev <= 1'b0;
			ius     <= 1'b0;
		end
		else
		begin
			rd_prev <= rd_s;
			// A new acknowledge wins over a simultaneous software release
			if (ack_s && rd_s && !rd_prev && ien_s && pending)
				ius <= 1'b1;
			else if (ius_clr)
				ius <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			chain_enable_out <= 1'b0;
			int_o            <= 1'b0;
			int_oe           <= 1'b0;
			data_o           <= '0;
			data_oe          <= 1'b0;
		end
		else
		begin
			if (ack_s)
				chain_enable_out <= ien_s & ~ius & ~pending;
			else
				chain_enable_out <= ien_s & ~ius;
			int_oe  <= pending & ~ius;
			data_oe <= ack_s & rd_s & ien_s;
			data_o  <= vector;
		end
	end

	// =====================================================================
	// Per-channel modem, sync, clock and request logic
	generate
		for (genvar c = 0; c < CH; c++)
		begin : g_ch
			sspl_pins_t pin_meta;
			sspl_pins_t pin_s;
			sspl_pins_t pin_prev;
			sspl_mode_t mode;
			sspl_mult_t mult;
			logic       auto_en;
			logic       sync_out_mode;
			logic       wsel;
			logic [7:0] st_clr;
			logic [5:0] div_cnt;
			logic [5:0] div_last;
			logic       rtclk_rise;
			logic       rts_hold;
			logic [2:0] rel_cnt;
			logic       req_act;

			assign mode    = sspl_mode_t'(cfg[c].line_mode[LM_MODE_LO +: 2]);
			assign mult    = sspl_mult_t'(cfg[c].line_mode[LM_MULT_LO +: 2]);
			assign auto_en = cfg[c].rx_ctrl[RXC_AUTO_EN];
			assign sync_out_mode = (mode == SSPL_INT_SYNC || mode == SSPL_SDLC)
				&& cfg[c].line_mode[LM_SYNC_EN] && !cfg[c].line_mode[LM_XTAL];
			assign wsel    = commit && w_strb[0] && aw_addr < CH_SPAN && wr_ch == c;
			assign st_clr  = (wsel && wr_ofs == OFS_STATUS) ? wbyte : 8'h00;
			assign rtclk_rise = pin_s.rtclk & ~pin_prev.rtclk;
			assign ch_pending[c] = status[c][ST_CTS_CHG] | status[c][ST_DCD_CHG];

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_meta <= '1;
					pin_s    <= '1;
					pin_prev <= '1;
				end
				else
				begin
					pin_meta <= {cts_n[c], dcd_n[c], sync_pin_i[c], rx_tx_clock_pin[c]};
					pin_s    <= pin_meta;
					pin_prev <= pin_s;
				end
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					cfg[c] <= '{CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
				else if (wsel)
				begin
					unique case (wr_ofs)
						OFS_RX_CTRL:   cfg[c].rx_ctrl   <= wbyte;
						OFS_TX_CTRL:   cfg[c].tx_ctrl   <= wbyte;
						OFS_LINE_MODE: cfg[c].line_mode <= wbyte;
						OFS_MISC:      cfg[c].misc      <= wbyte;
						OFS_EXT:       cfg[c].ext       <= wbyte;
						default:       ;
					endcase
				end
			end

			// Change flags are sticky; an edge in the clearing cycle survives
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					status[c] <= '0;
				else
				begin
					status[c][ST_CTS]  <= ~pin_s.cts_n;
					status[c][ST_DCD]  <= ~pin_s.dcd_n;
					status[c][ST_SYNC] <= ~pin_s.sync_n;
					status[c][ST_CTS_CHG] <= (status[c][ST_CTS_CHG] & ~st_clr[ST_CTS_CHG])
						| (pin_s.cts_n ^ pin_prev.cts_n);
					status[c][ST_DCD_CHG] <= (status[c][ST_DCD_CHG] & ~st_clr[ST_DCD_CHG])
						| (pin_s.dcd_n ^ pin_prev.dcd_n);
					// Sync edges only mark status, never request an interrupt
					status[c][ST_SYNC_CHG] <= (status[c][ST_SYNC_CHG]
						& ~st_clr[ST_SYNC_CHG])
						| (!sync_out_mode && (pin_s.sync_n ^ pin_prev.sync_n));
				end
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					tx_enable[c] <= 1'b0;
					rx_enable[c] <= 1'b0;
				end
				else
				begin
					tx_enable[c] <= auto_en ? ~pin_s.cts_n : 1'b1;
					rx_enable[c] <= auto_en ? ~pin_s.dcd_n : 1'b1;
				end
			end

			// Request-to-send: hold the line active until the drain condition
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					rts_hold <= 1'b0;
					rts_n[c] <= 1'b1;
				end
				else if (cfg[c].tx_ctrl[TXC_RTS])
				begin
					rts_hold <= 1'b1;
					rts_n[c] <= 1'b0;
				end
				else if (mode == SSPL_SDLC && cfg[c].ext[EXT_RTS_FLAG] && rts_hold)
				begin
					rts_hold <= ~closing_flag_done[c];
					rts_n[c] <= closing_flag_done[c];
				end
				else if (auto_en && mode == SSPL_ASYNC && rts_hold)
				begin
					rts_hold <= ~tx_empty[c];
					rts_n[c] <= tx_empty[c];
				end
				else
				begin
					rts_hold <= 1'b0;
					rts_n[c] <= 1'b1;
				end
			end

			// Sync pin turns round only in the sync output modes
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync_pin_oe[c] <= 1'b0;
					sync_pin_o[c]  <= 1'b1;
					char_start[c]  <= 1'b0;
				end
				else
				begin
					sync_pin_oe[c] <= sync_out_mode;
					if (mode == SSPL_SDLC)
						sync_pin_o[c] <= ~flag_found[c];
					else
						sync_pin_o[c] <= ~sync_found[c];
					char_start[c] <= mode == SSPL_EXT_SYNC && !cfg[c].line_mode[LM_XTAL]
						&& !pin_s.sync_n && pin_prev.sync_n;
				end
			end

			// Bit-rate divider counts receive clock edges seen by aclk
			always_comb
			begin
				unique case (mult)
					SSPL_X1:  div_last = 6'd0;
					SSPL_X16: div_last = 6'd15;
					SSPL_X32: div_last = 6'd31;
					SSPL_X64: div_last = 6'd63;
				endcase
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					div_cnt           <= '0;
					rx_sample_tick[c] <= 1'b0;
				end
				else
				begin
					rx_sample_tick[c] <= rtclk_rise && div_cnt >= div_last;
					if (rtclk_rise)
						div_cnt <= (div_cnt >= div_last) ? 6'd0 : div_cnt + 6'd1;
				end
			end

			// Ready/request with programmable release delay
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					rel_cnt <= '0;
					req_act <= 1'b0;
					terminal_ready_or_request_n[c] <= 1'b1;
				end
				else
				begin
					if (tx_dma_need[c])
					begin
						req_act <= 1'b1;
						rel_cnt <= REQ_RELEASE_CYCLES - 3'd1;
					end
					else if (cfg[c].ext[EXT_REQ_FAST] || rel_cnt == '0)
						req_act <= 1'b0;
					else
						rel_cnt <= rel_cnt - 3'd1;
					if (cfg[c].misc[MISC_REQ_SEL])
						terminal_ready_or_request_n[c] <= ~(tx_dma_need[c]
							| (req_act & ~cfg[c].ext[EXT_REQ_FAST] & rel_cnt != '0));
					else
						terminal_ready_or_request_n[c] <= ~cfg[c].tx_ctrl[TXC_DTR];
				end
			end

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					wait_or_request_o[c]  <= 1'b0;
					wait_or_request_oe[c] <= 1'b0;
				end
				else if (cfg[c].misc[MISC_WREQ])
				begin
					wait_or_request_o[c]  <= ~wait_need[c];
					wait_or_request_oe[c] <= 1'b1;
				end
				else
				begin
					wait_or_request_o[c]  <= 1'b0;
					wait_or_request_oe[c] <= wait_need[c];
				end
			end
		end
	endgenerate

endmodule

// file: shared/sspl_pkg.sv
// Shared constants, register map and carrier types of the serial pin logic
package sspl_pkg;

	localparam int unsigned NUM_CH = 2;
	localparam int unsigned ADDR_W = 8;

	// =====================================================================
	// Register map (byte addresses, channel B adds the stride)
	localparam logic [7:0] OFS_RX_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TX_CTRL   = 8'h04;
	localparam logic [7:0] OFS_LINE_MODE = 8'h08;
	localparam logic [7:0] OFS_MISC      = 8'h0c;
	localparam logic [7:0] OFS_EXT       = 8'h10;
	localparam logic [7:0] OFS_STATUS    = 8'h14;
	localparam logic [7:0] CH_STRIDE     = 8'h20;
	localparam logic [7:0] CH_SPAN       = 8'h40;
	localparam logic [7:0] OFS_VECTOR    = 8'h40;
	localparam logic [7:0] OFS_IRQ_CTRL  = 8'h44;
	localparam int unsigned CH_SEL_BIT   = 5;

	// =====================================================================
	// Field positions
	localparam int unsigned RXC_AUTO_EN  = 5;
	localparam int unsigned TXC_RTS      = 1;
	localparam int unsigned TXC_DTR      = 7;
	localparam int unsigned MISC_WREQ    = 1;
	localparam int unsigned MISC_REQ_SEL = 2;
	localparam int unsigned EXT_RTS_FLAG = 2;
	localparam int unsigned EXT_REQ_FAST = 4;
	localparam int unsigned LM_MODE_LO   = 0;
	localparam int unsigned LM_SYNC_EN   = 2;
	localparam int unsigned LM_XTAL      = 3;
	localparam int unsigned LM_MULT_LO   = 4;
	localparam int unsigned ST_CTS       = 0;
	localparam int unsigned ST_DCD       = 1;
	localparam int unsigned ST_SYNC      = 2;
	localparam int unsigned ST_CTS_CHG   = 4;
	localparam int unsigned ST_DCD_CHG   = 5;
	localparam int unsigned ST_SYNC_CHG  = 6;
	localparam int unsigned IRQ_IUS      = 0;
	localparam int unsigned IRQ_PEND     = 1;

	// =====================================================================
	// Reset values and timing
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [7:0] VECTOR_RESET = 8'h00;
	localparam logic [2:0] REQ_RELEASE_CYCLES = 3'h4;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0]
	{
		SSPL_ASYNC    = 2'b00,
		SSPL_EXT_SYNC = 2'b01,
		SSPL_INT_SYNC = 2'b10,
		SSPL_SDLC     = 2'b11
	} sspl_mode_t;

	typedef enum logic [1:0]
	{
		SSPL_X1  = 2'b00,
		SSPL_X16 = 2'b01,
		SSPL_X32 = 2'b10,
		SSPL_X64 = 2'b11
	} sspl_mult_t;

	typedef struct packed
	{
		logic [7:0] rx_ctrl;
		logic [7:0] tx_ctrl;
		logic [7:0] line_mode;
		logic [7:0] misc;
		logic [7:0] ext;
	} sspl_cfg_t;

	// Modem-side pins of one channel, as seen after the synchroniser
	typedef struct packed
	{
		logic cts_n;
		logic dcd_n;
		logic sync_n;
		logic rtclk;
	} sspl_pins_t;

endpackage

// file: test/sspl_modem_model.sv
// Modem and line side model: modem pins, sync line and a gated receive clock
module sspl_modem_model
	import sspl_pkg::*;
(
	input wire logic  aclk,            // Clock
	output logic [1:0] cts_n,          // Clear to send
	output logic [1:0] dcd_n,          // Carrier detect
	output logic [1:0] sync_pin_i,     // Sync wire level
	input wire logic [1:0] sync_pin_o, // Sync drive value
	input wire logic [1:0] sync_pin_oe, // Sync drive enable
	output logic [1:0] rx_tx_clock_pin // Receive clock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] drv_sync;
	initial
	begin
		cts_n = '1;
		dcd_n = '1;
		drv_sync = '1;
		rx_tx_clock_pin = '0;
	end
	// Design owns the wire while enabled
	assign sync_pin_i = (sync_pin_oe & sync_pin_o) | (~sync_pin_oe & drv_sync);
	task pins(input logic [1:0] c, input logic [1:0] d, input logic [1:0] s);
		@(posedge aclk);
		cts_n <= c;
		dcd_n <= d;
		drv_sync <= s;
	endtask
	// Clock stands low between bursts, off phase with the master clock
	task burst(input int n);
		#3;
		repeat (n)
		begin
			#62.5 rx_tx_clock_pin = 2'b01;
			#62.5 rx_tx_clock_pin = 2'b00;
		end
	endtask
endmodule

// file: test/sspl_pin_props.sv
// Port-level assertions for the serial pin logic
module sspl_pin_props
	import sspl_pkg::*;
#(
	parameter int unsigned CH = NUM_CH
)
(
	input wire logic          aclk,               // Clock
	input wire logic          aresetn,            // Reset
	input wire logic          address_strobe_n,   // Address strobe
	input wire logic          data_strobe_n,      // Data strobe
	input wire logic          reset_request,      // Reset request
	input wire logic          int_o,              // Interrupt value
	input wire logic          chain_enable_in,    // Chain in
	input wire logic          chain_enable_out,   // Chain out
	input wire logic          irq_acknowledge_n,  // Acknowledge
	input wire logic          data_oe,            // Vector enable
	input wire logic [CH-1:0] wait_or_request_oe, // Wait enable
	input wire logic [CH-1:0] sync_pin_o,         // Sync value
	input wire logic [CH-1:0] sync_found,         // Sync seen
	input wire logic [CH-1:0] flag_found,         // Flag seen
	input wire logic [CH-1:0] rx_sample_tick,     // Bit tick
	input wire logic [CH-1:0] char_start          // Assembly start
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==================================================================
	// Pin relations
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_strobe_reset: assert property ((!address_strobe_n && !data_strobe_n) [*5] |-> reset_request)
		else $error("reset request missing");
	a_int_drain: assert property (!int_o)
		else $error("interrupt pin driven high");
	a_wait_reset: assert property ($rose(aresetn) |-> wait_or_request_oe == '0)
		else $error("wait pin driven after reset");
	a_chain_block: assert property (!chain_enable_in [*5] |-> !chain_enable_out)
		else $error("enable out without enable in");
	a_vector_ack: assert property (irq_acknowledge_n [*5] |-> !data_oe)
		else $error("vector driven outside acknowledge");
	a_sync_cause: assert property ($fell(sync_pin_o[0]) |-> $past(sync_found[0] | flag_found[0]))
		else $error("sync pulse without cause");
	a_tick_pulse: assert property (rx_sample_tick[0] |=> !rx_sample_tick[0])
		else $error("tick longer than one cycle");
	a_start_pulse: assert property (char_start[0] |=> !char_start[0])
		else $error("start longer than one cycle");
endmodule

bind sspl_pin_logic sspl_pin_props #(.CH(CH)) i_props (.aclk, .aresetn, .address_strobe_n,
	.data_strobe_n, .reset_request, .int_o, .chain_enable_in, .chain_enable_out,
	.irq_acknowledge_n, .data_oe, .wait_or_request_oe, .sync_pin_o, .sync_found, .flag_found,
	.rx_sample_tick, .char_start);

// file: test/testbench.sv
// Register-driven self-checking bench of the serial pin logic
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
	import sspl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, data_o;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, cts_n, dcd_n, sync_pin_i, sync_pin_o, sync_pin_oe;
	logic [1:0] rx_tx_clock_pin, rts_n, terminal_ready_or_request_n, wait_or_request_o;
	logic [1:0] wait_or_request_oe, tx_empty, closing_flag_done, sync_found, flag_found;
	logic [1:0] tx_dma_need, wait_need, tx_enable, rx_enable, rx_sample_tick, char_start;
	logic chain_enable_in, chain_enable_out, int_o, int_oe, irq_acknowledge_n, read_strobe_n;
	logic data_oe, address_strobe_n, data_strobe_n, reset_request;
	int error_cnt, comparisons, cyc, nsync, nchar, ntick, n0;
	sspl_pin_logic i_dut (.*);
	sspl_modem_model i_modem (.*);
	initial
	begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	// Pulse counters
	always @(posedge aclk)
	begin
		cyc++;
		nsync += !sync_pin_o[0];
		nchar += char_start[0];
		ntick += rx_sample_tick[0];
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end
	task final_report();
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// ==================================================================
	// AXI4-Lite master
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 0;
		`CHK(s_axi_bresp, r)
	endtask
	task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 0;
		`CHK(s_axi_rdata, {24'h0, d})
		`CHK(s_axi_rresp, r)
	endtask
	task tend(input string s);
		$display("test %s done", s);
	endtask
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'h1;
		{tx_empty, closing_flag_done, sync_found, flag_found, tx_dma_need, wait_need} = 0;
		{chain_enable_in, irq_acknowledge_n, read_strobe_n, address_strobe_n, data_strobe_n} = '1;
		w(3);
		aresetn <= 1;
		w(2);
		`CHK(wait_or_request_oe, 2'b00)
		rd(CH_STRIDE + OFS_MISC, CFG_RESET);
		rd(8'h18, 8'h00, RESP_SLVERR);
		wr(8'h18, 8'h01, RESP_SLVERR);
		wr(OFS_TX_CTRL, 8'h02);
		w(2);
		`CHK(rts_n[0], 1'b0)
		wr(OFS_TX_CTRL, 8'h00);
		w(2);
		`CHK(rts_n[0], 1'b1)
		tend("registers");
		i_modem.pins(2'b10, 2'b10, 2'b11);
		wr(OFS_RX_CTRL, 8'h20);
		w(4);
		`CHK(tx_enable[0], 1'b1)
		`CHK(rx_enable[0], 1'b1)
		wr(OFS_TX_CTRL, 8'h02);
		wr(OFS_TX_CTRL, 8'h00);
		w(4);
		`CHK(rts_n[0], 1'b0)
		tx_empty <= 2'b01;
		w(3);
		`CHK(rts_n[0], 1'b1)
		wr(OFS_RX_CTRL, 8'h00);
		rd(OFS_STATUS, 8'h33);
		`CHK(int_oe, 1'b1)
		tend("modem");
		wr(OFS_VECTOR, 8'h5a);
		irq_acknowledge_n <= 0;
		read_strobe_n <= 0;
		w(6);
		`CHK(data_oe, 1'b1)
		`CHK(data_o, 8'h5a)
		`CHK(chain_enable_out, 1'b0)
		{irq_acknowledge_n, read_strobe_n} <= 2'b11;
		wr(OFS_IRQ_CTRL, 8'h01);
		wr(OFS_STATUS, 8'h30);
		w(3);
		`CHK(int_oe, 1'b0)
		`CHK(chain_enable_out, 1'b1)
		tend("acknowledge");
		wr(OFS_TX_CTRL, 8'h80);
		w(2);
		`CHK(terminal_ready_or_request_n[0], 1'b0)
		for (int i = 0; i < 2; i++)
		begin
			wr(OFS_EXT, i ? 8'h10 : 8'h00);
			wr(OFS_MISC, 8'h06);
			tx_dma_need <= 2'b01;
			w(3);
			`CHK(wait_or_request_oe[0], 1'b1)
			tx_dma_need <= 2'b00;
			w(3);
			`CHK(terminal_ready_or_request_n[0], i ? 1'b1 : 1'b0)
			w(4);
			`CHK(terminal_ready_or_request_n[0], 1'b1)
		end
		tend("request");
		for (int i = 0; i < 2; i++)
		begin
			wr(OFS_LINE_MODE, i ? 8'h07 : 8'h06);
			w(3);
			`CHK(sync_pin_oe[0], 1'b1)
			n0 = nsync;
			{flag_found[0], sync_found[0]} <= i ? 2'b10 : 2'b01;
			w(1);
			{flag_found, sync_found} <= 0;
			w(4);
			`CHK(nsync - n0, 1)
		end
		wr(OFS_EXT, 8'h04);
		wr(OFS_TX_CTRL, 8'h02);
		wr(OFS_TX_CTRL, 8'h00);
		w(3);
		`CHK(rts_n[0], 1'b0)
		closing_flag_done <= 2'b01;
		w(3);
		`CHK(rts_n[0], 1'b1)
		tend("sync out");
		wr(OFS_LINE_MODE, 8'h00);
		i_modem.pins(2'b10, 2'b10, 2'b10);
		w(6);
		rd(OFS_STATUS, 8'h47);
		`CHK(int_oe, 1'b0)
		wr(OFS_LINE_MODE, 8'h01);
		i_modem.pins(2'b10, 2'b11, 2'b11);
		w(6);
		n0 = nchar;
		i_modem.pins(2'b10, 2'b11, 2'b10);
		w(8);
		`CHK(nchar - n0, 1)
		wr(OFS_LINE_MODE, 8'h00);
		n0 = ntick;
		i_modem.burst(8);
		w(6);
		`CHK(ntick - n0, 8)
		tend("sync in");
		{address_strobe_n, data_strobe_n} <= 2'b00;
		w(6);
		`CHK(reset_request, 1'b1)
		{address_strobe_n, data_strobe_n} <= 2'b11;
		chain_enable_in <= 0;
		w(6);
		`CHK(chain_enable_out, 1'b0)
		tend("strobes");
		final_report();
	end
endmodule
